// >>> core/output_mux_pkg.sv
/*
 output terminal mux package: register offsets, reset values, function and
 meter codes, meter timing constants.
 assumes a 32-bit apb register bus with word aligned registers.
*/
package output_mux_pkg;
   // register byte offsets
   localparam logic [7:0] out1_func_off   = 8'h00;
   localparam logic [7:0] out2_func_off   = 8'h04;
   localparam logic [7:0] meter_func_off  = 8'h08;
   localparam logic [7:0] relay_func_off  = 8'h0C;
   localparam logic [7:0] out1_pol_off    = 8'h10;
   localparam logic [7:0] out2_pol_off    = 8'h14;
   localparam logic [7:0] relay_pol_off   = 8'h18;
   localparam logic [7:0] variant_off     = 8'h1C;
   localparam logic [7:0] status_off      = 8'h20;
   // reset values
   localparam logic [7:0] out1_func_rst   = 8'h01;
   localparam logic [7:0] out2_func_rst   = 8'h00;
   localparam logic [7:0] meter_func_rst  = 8'h00;
   localparam logic [7:0] relay_func_rst  = 8'h05;
   localparam logic [7:0] out1_pol_rst    = 8'h00;
   localparam logic [7:0] out2_pol_rst    = 8'h00;
   localparam logic [7:0] relay_pol_rst   = 8'h01;
   localparam logic [7:0] variant_rst     = 8'h00;
   // function codes
   localparam logic [7:0] fn_run          = 8'h00;
   localparam logic [7:0] fn_arrival      = 8'h01;
   localparam logic [7:0] fn_over         = 8'h02;
   localparam logic [7:0] fn_overload     = 8'h03;
   localparam logic [7:0] fn_deviation    = 8'h04;
   localparam logic [7:0] fn_alarm        = 8'h05;
   localparam logic [7:0] meter_freq_pwm  = 8'h00;
   localparam logic [7:0] meter_cur_pwm   = 8'h01;
   localparam logic [7:0] meter_freq_sq   = 8'h02;
   localparam logic [7:0] pol_closed      = 8'h01;
   // meter timing: pwm period fixed by the divider and counter width
   localparam int         pwm_bits        = 10;
   localparam int         pwm_div_cycles  = 10;
   localparam logic [31:0] unmapped_data  = 32'h0000_0000;
endpackage

// >>> core/status_latch.sv
/*
 status_latch: hysteresis-free compare with hold on equality.
 assumes quantity and threshold share one unsigned scale.
*/
`timescale 1ns/1ps
module status_latch #(
   parameter int width = 16
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic [width-1:0] value,
   input  wire logic [width-1:0] threshold,
   output logic                  flag_q
);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_q <= 1'b0;
      end else if (value > threshold) begin
         flag_q <= 1'b1;
      end else if (value < threshold) begin
         flag_q <= 1'b0;
      end
   end
endmodule // status_latch

// >>> core/pwm_gen.sv
/*
 pwm_gen: fixed-period pulse-width generator, stepped by an enable pulse.
 assumes duty is a fraction of full scale 2**bits.
*/
`timescale 1ns/1ps
module pwm_gen #(
   parameter int bits = 10
) (
   input  wire logic            pclk,
   input  wire logic            presetn,
   input  wire logic            step,
   input  wire logic [bits:0]   duty,
   output logic                 pwm_q
);
   logic [bits-1:0] cnt_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= '0;
         pwm_q <= 1'b0;
      end else if (step) begin
         cnt_q <= cnt_q + 1'b1;
         pwm_q <= ({1'b0, cnt_q} < duty);
      end
   end
endmodule // pwm_gen

// >>> core/output_terminal_mux.sv
/*
 output_terminal_mux: two logic outputs and an alarm relay, each fed from a
 selectable drive status source with programmable polarity except output two on variants (fixed active low), and a meter output.
 assumes status inputs synchronous to pclk; apb slave with zero wait states.
*/
// The placing of the registers and the APB slave port were left to the implementer.
//
// Function
// - output one takes one of six functions, default code 01
// - output two takes one of six functions, default code 00
// - meter takes one of three monitor functions, default code 00
// - relay takes one of six functions, default code 05
// - logic output polarity 00 active low, 01 active high, default low
// - relay polarity same codes, default 01
// - on variants, second polarity setting drives output one
// - code 00 asserts while running, off when stopped
// - code 01 asserts only at set frequency, not off or ramping
// - code 02 asserts at or above set frequency, even ramping
// - code 03 asserts when current exceeds overload threshold
// - code 04 asserts when pid error exceeds deviation threshold
// - code 05 asserts after alarm until it is cleared
// - meter code 00 pwm duty proportional to frequency
// - meter code 01 pwm duty full at 200 percent current
// - meter code 02 fifty percent square at output frequency
// - overload threshold 0 to 200 percent, warning only
// - pid threshold 0 to 100 percent in 0.1 steps on abs error
`timescale 1ns/1ps
module output_terminal_mux
   import output_mux_pkg::*;
#(
   parameter int freq_bits = 16,
   parameter int cur_bits  = 16,
   parameter int pid_bits  = 10
) (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic                 drive_running,
   input  wire logic                 output_enabled,
   input  wire logic                 ramping,
   input  wire logic [freq_bits-1:0] out_freq,
   input  wire logic [freq_bits-1:0] set_freq,
   input  wire logic [freq_bits-1:0] max_freq,
   input  wire logic [cur_bits-1:0]  out_current,
   input  wire logic [cur_bits-1:0]  rated_current,
   input  wire logic [cur_bits-1:0]  overload_level,
   input  wire logic [pid_bits-1:0]  pid_setpoint,
   input  wire logic [pid_bits-1:0]  pid_process,
   input  wire logic [pid_bits-1:0]  pid_dev_level,
   input  wire logic                 alarm_event,
   input  wire logic                 alarm_clear,
   input  wire logic                 freq_tick,
   output logic                      logic_out_one,
   output logic                      logic_out_two,
   output logic                      relay_out,
   output logic                      meter_output
);
   ////////////////////////////////////////////////////////////////////////////
   // state
   typedef struct packed {
      logic [7:0]  out1_func;
      logic [7:0]  out2_func;
      logic [7:0]  meter_func;
      logic [7:0]  relay_func;
      logic [7:0]  out1_pol;
      logic [7:0]  out2_pol;
      logic [7:0]  relay_pol;
      logic [7:0]  variant;
      logic        alarm_flag;
      logic        square;
      logic [7:0]  div;
      logic [31:0] rdata;
      logic        ready;
      logic        err;
      logic        o1;
      logic        o2;
      logic        ry;
      logic        fm;
   } regs_s;

   regs_s s_q;
   regs_s s_d;

   localparam logic [7:0] div_last = 8'(pwm_div_cycles - 1);

   ////////////////////////////////////////////////////////////////////////////
   // status word bit positions, shared by the selectors and the status read
   localparam int st_run      = 0;
   localparam int st_arrival  = 1;
   localparam int st_over     = 2;
   localparam int st_overload = 3;
   localparam int st_dev      = 4;
   localparam int st_alarm    = 5;
   localparam int var_swap    = 0;

   logic                overload_warning;
   logic                pid_deviation_flag;
   logic                arrival_at_speed;
   logic                arrival_over_speed;
   logic [pid_bits-1:0] pid_error;
   logic                pwm_step;
   logic                pwm_freq;
   logic                pwm_cur;
   logic [pwm_bits:0]   duty_freq;
   logic [pwm_bits:0]   duty_cur;

   ////////////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic pick(input logic [7:0] code, input logic [5:0] src);
      logic r;
      r = 1'b0;
      case (code)
         fn_run:       r = src[st_run];
         fn_arrival:   r = src[st_arrival];
         fn_over:      r = src[st_over];
         fn_overload:  r = src[st_overload];
         fn_deviation: r = src[st_dev];
         fn_alarm:     r = src[st_alarm];
         default:      r = 1'b0;
      endcase
      return r;
   endfunction

   function automatic logic polar(input logic v, input logic [7:0] pol);
      // open: conducting low when active; closed: active high
      return (pol == pol_closed) ? v : ~v;
   endfunction

   function automatic logic [31:0] zext(input logic [7:0] v);
      // settings are one byte wide, upper read bits are zero
      return {24'h00_0000, v};
   endfunction

   function automatic logic [pwm_bits:0] scale(input logic [31:0] num,
                                              input logic [31:0] den);
      logic [63:0] q;
      q = 64'h0000_0000_0000_0000;
      if (den != 32'h0000_0000) begin
         q = ({32'h0000_0000, num} << pwm_bits) / {32'h0000_0000, den};
      end
      if (q > (64'h1 << pwm_bits)) begin
         q = 64'h1 << pwm_bits;
      end
      return q[pwm_bits:0];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // status sources
   assign pid_error = (pid_setpoint >= pid_process) ? pid_setpoint - pid_process
                                                    : pid_process - pid_setpoint;

   status_latch #(.width(cur_bits)) u_overload (
      .pclk      (pclk),
      .presetn   (presetn),
      .value     (out_current),
      .threshold (overload_level),
      .flag_q    (overload_warning)
   );

   status_latch #(.width(pid_bits)) u_deviation (
      .pclk      (pclk),
      .presetn   (presetn),
      .value     (pid_error),
      .threshold (pid_dev_level),
      .flag_q    (pid_deviation_flag)
   );

   assign arrival_at_speed   = output_enabled && !ramping && (out_freq == set_freq);
   assign arrival_over_speed = output_enabled && (out_freq >= set_freq);

   ////////////////////////////////////////////////////////////////////////////
   // meter pwm
   assign pwm_step  = (s_q.div == div_last);
   assign duty_freq = scale(32'(out_freq), 32'(max_freq));
   assign duty_cur  = scale(32'(out_current), {31'(rated_current), 1'b0});

   pwm_gen #(.bits(pwm_bits)) u_pwm_freq (
      .pclk    (pclk),
      .presetn (presetn),
      .step    (pwm_step),
      .duty    (duty_freq),
      .pwm_q   (pwm_freq)
   );

   pwm_gen #(.bits(pwm_bits)) u_pwm_cur (
      .pclk    (pclk),
      .presetn (presetn),
      .step    (pwm_step),
      .duty    (duty_cur),
      .pwm_q   (pwm_cur)
   );

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      logic       wr;
      logic       rd;
      logic       hit;
      logic [5:0] src;
      logic [7:0] p1;
      logic [7:0] p2;
      wr  = 1'b0;
      rd  = 1'b0;
      hit = 1'b0;
      src = 6'b00_0000;
      p1  = 8'h00;
      p2  = 8'h00;
      s_d = s_q;
      s_d.ready = 1'b0;
      s_d.err   = 1'b0;
      s_d.div   = pwm_step ? 8'h00 : s_q.div + 8'h01;
      // alarm latch, a new alarm wins over the clear
      if (alarm_event) begin
         s_d.alarm_flag = 1'b1;
      end else if (alarm_clear) begin
         s_d.alarm_flag = 1'b0;
      end
      if (freq_tick) begin
         s_d.square = ~s_q.square;
      end
      src[st_run]      = drive_running;
      src[st_arrival]  = arrival_at_speed;
      src[st_over]     = arrival_over_speed;
      src[st_overload] = overload_warning;
      src[st_dev]      = pid_deviation_flag;
      src[st_alarm]    = s_q.alarm_flag;
      // apb: answer in the access cycle
      if (psel && !penable) begin
         s_d.ready = 1'b1;
         wr = pwrite;
         rd = !pwrite;
         s_d.rdata = unmapped_data;
         if (paddr == out1_func_off) begin
            hit = 1'b1;
            s_d.rdata = zext(s_q.out1_func);
         end else if (paddr == out2_func_off) begin
            hit = 1'b1;
            s_d.rdata = zext(s_q.out2_func);
         end else if (paddr == meter_func_off) begin
            hit = 1'b1;
            s_d.rdata = zext(s_q.meter_func);
         end else if (paddr == relay_func_off) begin
            hit = 1'b1;
            s_d.rdata = zext(s_q.relay_func);
         end else if (paddr == out1_pol_off) begin
            hit = 1'b1;
            s_d.rdata = zext(s_q.out1_pol);
         end else if (paddr == out2_pol_off) begin
            hit = 1'b1;
            s_d.rdata = zext(s_q.out2_pol);
         end else if (paddr == relay_pol_off) begin
            hit = 1'b1;
            s_d.rdata = zext(s_q.relay_pol);
         end else if (paddr == variant_off) begin
            hit = 1'b1;
            s_d.rdata = zext(s_q.variant);
         end else if (paddr == status_off) begin
            hit = !wr;
            s_d.rdata = {26'h000_0000, src};
         end
         // writes refused while running
         s_d.err = !hit || (wr && drive_running);
         if (wr && hit && !drive_running) begin
            if (paddr == out1_func_off) begin
               s_d.out1_func = pwdata[7:0];
            end else if (paddr == out2_func_off) begin
               s_d.out2_func = pwdata[7:0];
            end else if (paddr == meter_func_off) begin
               s_d.meter_func = pwdata[7:0];
            end else if (paddr == relay_func_off) begin
               s_d.relay_func = pwdata[7:0];
            end else if (paddr == out1_pol_off) begin
               s_d.out1_pol = pwdata[7:0];
            end else if (paddr == out2_pol_off) begin
               s_d.out2_pol = pwdata[7:0];
            end else if (paddr == relay_pol_off) begin
               s_d.relay_pol = pwdata[7:0];
            end else if (paddr == variant_off) begin
               s_d.variant = pwdata[7:0];
            end
         end
         if (rd || !hit) begin
            s_d.rdata = hit ? s_d.rdata : unmapped_data;
         end
      end
      // outputs
      p1  = s_q.variant[var_swap] ? s_q.out2_pol : s_q.out1_pol;
      p2  = s_q.variant[var_swap] ? out2_pol_rst : s_q.out2_pol;
      s_d.o1 = polar(pick(s_q.out1_func, src), p1);
      s_d.o2 = polar(pick(s_q.out2_func, src), p2);
      s_d.ry = polar(pick(s_q.relay_func, src), s_q.relay_pol);
      case (s_q.meter_func)
         meter_freq_pwm: s_d.fm = pwm_freq;
         meter_cur_pwm:  s_d.fm = pwm_cur;
         meter_freq_sq:  s_d.fm = s_q.square;
         default:        s_d.fm = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '{out1_func:  out1_func_rst,
                  out2_func:  out2_func_rst,
                  meter_func: meter_func_rst,
                  relay_func: relay_func_rst,
                  out1_pol:   out1_pol_rst,
                  out2_pol:   out2_pol_rst,
                  relay_pol:  relay_pol_rst,
                  variant:    variant_rst,
                  alarm_flag: 1'b0,
                  square:     1'b0,
                  div:        8'h00,
                  rdata:      32'h0000_0000,
                  ready:      1'b0,
                  err:        1'b0,
                  o1:         1'b1,
                  o2:         1'b1,
                  ry:         1'b0,
                  fm:         1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata        = s_q.rdata;
   assign pready        = s_q.ready;
   assign pslverr       = s_q.err;
   assign logic_out_one = s_q.o1;
   assign logic_out_two = s_q.o2;
   assign relay_out     = s_q.ry;
   assign meter_output  = s_q.fm;
endmodule // output_terminal_mux

// >>> bench/output_terminal_mux_props.sv
/*
 output_terminal_mux_props: port level checks of the output terminal mux.
 assumes zero-wait apb and that writes made while running are refused and leave the settings unchanged.
*/
`timescale 1ns/1ps
module output_terminal_mux_props
   import output_mux_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        drive_running,
   input wire logic        alarm_event,
   input wire logic        alarm_clear,
   input wire logic        logic_out_two,
   input wire logic        relay_out
);
   logic [7:0] f2_q, p2_q, rf_q, rp_q;
   logic       var_q;
   ////////////////////////////////////////////////////////////////////////////
   // shadow of the settings, updated by accepted writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         f2_q  <= out2_func_rst;
         p2_q  <= out2_pol_rst;
         rf_q  <= relay_func_rst;
         rp_q  <= relay_pol_rst;
         var_q <= 1'b0;
      end else if (psel && !penable && pwrite && !drive_running) begin
         if (paddr == out2_func_off) f2_q <= pwdata[7:0];
         if (paddr == out2_pol_off) p2_q <= pwdata[7:0];
         if (paddr == relay_func_off) rf_q <= pwdata[7:0];
         if (paddr == relay_pol_off) rp_q <= pwdata[7:0];
         if (paddr == variant_off) var_q <= pwdata[0];
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_ready; psel && !penable |=> pready; endproperty
   a_ready: assert property (p_ready) else $error("no ready after setup");
   property p_pulse; pready |=> !pready; endproperty
   a_pulse: assert property (p_pulse) else $error("ready held too long");
   property p_refuse; psel && !penable && pwrite && drive_running |=> pslverr; endproperty
   a_refuse: assert property (p_refuse) else $error("write while running taken");
   property p_unmapped;
      psel && !penable && paddr > status_off |=> pslverr && prdata == unmapped_data;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access answered");
   property p_upper; pready |-> prdata[31:8] == 24'h00_0000; endproperty
   a_upper: assert property (p_upper) else $error("upper read bits set");
   property p_run2;
      ($stable(p2_q) && $stable(drive_running) && f2_q == fn_run && !var_q)[*3]
         |-> logic_out_two == (drive_running == (p2_q == pol_closed));
   endproperty
   a_run2: assert property (p_run2) else $error("run output wrong");
   property p_alarm_set;
      (rf_q == fn_alarm && rp_q == pol_closed)[*2] ##0 alarm_event |-> ##[1:3] relay_out;
   endproperty
   a_alarm_set: assert property (p_alarm_set) else $error("alarm not shown");
   property p_alarm_hold;
      (rf_q == fn_alarm && rp_q == pol_closed && !alarm_clear)[*3] ##0 relay_out |=> relay_out;
   endproperty
   a_alarm_hold: assert property (p_alarm_hold) else $error("alarm dropped");
   c_write: cover property (pready && pwrite && !pslverr);
   c_error: cover property (pready && pslverr);
   c_alarm: cover property (alarm_event ##2 relay_out);
endmodule // output_terminal_mux_props

bind output_terminal_mux output_terminal_mux_props u_props (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .drive_running, .alarm_event,
   .alarm_clear, .logic_out_two, .relay_out);

// >>> bench/terminal_loads.sv
/*
 terminal_loads: meter load that counts high cycles of the meter output.
 assumes start is a one-cycle pulse from the bench.
*/
`timescale 1ns/1ps
module terminal_loads #(
   parameter int window = 10240
) (
   input wire logic pclk,
   input wire logic start,
   input wire logic meter_output,
   output int       high_count,
   output logic     done
);
   int n = 0;
   initial high_count = 0;
   initial done = 1'b0;
   always @(posedge pclk) begin
      if (start) begin
         high_count <= 0;
         n          <= window;
         done       <= 1'b0;
      end else if (n > 0) begin
         high_count <= high_count + int'(meter_output);
         n          <= n - 1;
         done       <= (n == 1);
      end
   end
endmodule // terminal_loads

// >>> bench/output_terminal_mux_tb.sv
/*
 output_terminal_mux_tb: bench with a settings and status model.
 assumes zero-wait apb slave and a meter load counting one pwm period.
*/
`timescale 1ns/1ps
module output_terminal_mux_tb;
   import output_mux_pkg::*;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 0;
   logic [31:0] pwdata = 0, prdata;
   logic        pready, pslverr, logic_out_one, logic_out_two, relay_out, meter_output;
   logic        drive_running = 0, output_enabled = 0, ramping = 0, alarm_event = 0;
   logic        alarm_clear = 0, freq_tick = 0, mstart = 0, mdone, alm = 0;
   logic [15:0] out_freq = 0, set_freq = 0, max_freq = 16'h4000;
   logic [15:0] out_current = 0, rated_current = 16'h0800, overload_level = 0;
   logic [9:0]  pid_setpoint = 0, pid_process = 0, pid_dev_level = 0;
   logic [7:0]  cfg [0:7] = '{8'h01, 8'h00, 8'h00, 8'h05, 8'h00, 8'h00, 8'h01, 8'h00};
   logic [7:0]  fo [0:2] = '{out1_func_off, out2_func_off, relay_func_off};
   logic [7:0]  po [0:2] = '{out1_pol_off, out2_pol_off, relay_pol_off};
   int          fail_count = 0, checked = 0, hcount, rnd, ex;
   output_terminal_mux u_output_terminal_mux (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .drive_running, .output_enabled, .ramping, .out_freq,
      .set_freq, .max_freq, .out_current, .rated_current, .overload_level, .pid_setpoint,
      .pid_process, .pid_dev_level, .alarm_event, .alarm_clear, .freq_tick, .logic_out_one,
      .logic_out_two, .relay_out, .meter_output);
   terminal_loads u_terminal_loads (.pclk, .start(mstart), .meter_output, .high_count(hcount),
      .done(mdone));
   always #5 pclk = ~pclk;
   always begin
      repeat (15) @(posedge pclk);
      freq_tick <= 1'b1;
      @(posedge pclk);
      freq_tick <= 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task summarize;
      $display("checked=%0d fail_count=%0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
            output logic er);
      @(posedge pclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] rd;
      logic        er;
      apb(1, a, {24'h00_0000, d}, rd, er);
      check(er, drive_running || a > variant_off);
      if (!drive_running && a <= variant_off) cfg[a[4:2]] = d;
   endtask
   task rd_chk(input logic [7:0] a);
      logic [31:0] rd;
      logic        er;
      apb(0, a, 0, rd, er);
      check(er, a > status_off);
      check(rd, a <= variant_off ? {24'h00_0000, cfg[a[4:2]]} : unmapped_data);
   endtask
   function automatic logic fval(input logic [7:0] c);
      case (c)
         fn_run: return drive_running;
         fn_arrival: return output_enabled && !ramping && out_freq == set_freq;
         fn_over: return output_enabled && out_freq >= set_freq;
         fn_overload: return out_current > overload_level;
         fn_deviation: return (pid_setpoint > pid_process ? pid_setpoint - pid_process
                                                           : pid_process - pid_setpoint)
                              > pid_dev_level;
         fn_alarm: return alm;
         default: return 1'b0;
      endcase
   endfunction
   task stim;
      logic [31:0] r;
      r = $urandom;
      drive_running <= r[0]; output_enabled <= r[1]; ramping <= r[2];
      out_freq <= r[31:16];
      set_freq <= r[3] ? r[31:16] : 16'($urandom);
      out_current <= {r[15:5], 5'h00}; overload_level <= {r[14:4], 5'h01};
      pid_setpoint <= r[25:16]; pid_process <= {r[13:5], r[16]};
      pid_dev_level <= {r[12:4], 1'b1};
      alarm_event <= r[6]; alarm_clear <= r[7];
      alm = r[6] ? 1'b1 : (r[7] ? 1'b0 : alm);
      @(posedge pclk);
      alarm_event <= 0;
      alarm_clear <= 0;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #600_000;
      fail_count++;
      summarize;
   end
   initial begin
      rnd = $urandom(77252);
      repeat (6) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      check({logic_out_one, logic_out_two, relay_out}, 3'b110);
      for (int a = 0; a <= 36; a += 4) if (a != 32) rd_chk(8'(a));
      for (int k = 0; k < 3; k++) for (int c = 0; c < 6; c++) for (int p = 0; p < 4; p++) begin
         drive_running <= 0;
         @(posedge pclk);
         wr(fo[k], 8'(c));
         wr(po[k], 8'(p % 2));
         stim;
         repeat (4) @(posedge pclk);
         ex = (p % 2) ? fval(8'(c)) : !fval(8'(c));
         check({relay_out, logic_out_two, logic_out_one} >> k & 1, ex);
      end
      drive_running <= 1;
      wr(out2_func_off, fn_overload);
      rd_chk(out2_func_off);
      drive_running <= 0;
      wr(variant_off, 8'h01);
      wr(out1_func_off, fn_run);
      wr(out2_func_off, fn_run);
      wr(out1_pol_off, 8'h00);
      wr(out2_pol_off, pol_closed);
      drive_running <= 1;
      repeat (4) @(posedge pclk);
      check({logic_out_one, logic_out_two}, 2'b10);
      drive_running <= 0;
      wr(variant_off, 8'h00);
      for (int m = 0; m < 4; m++) begin
         wr(meter_func_off, m == 3 ? meter_freq_sq : (m == 0 ? meter_freq_pwm : meter_cur_pwm));
         out_freq <= 16'h1000;
         out_current <= m == 2 ? 16'h1800 : 16'h0800;
         repeat (300) @(posedge pclk);
         mstart <= 1;
         @(posedge pclk);
         mstart <= 0;
         @(posedge pclk);
         for (int n = 0; n < 10400 && mdone !== 1'b1; n++) @(posedge pclk);
         check(mdone, 1'b1);
         ex = m == 0 ? 10 * (1024 * 16'h1000 / 16'h4000) : (m == 1 ? 5120 : (m == 2 ? 10240 : 5120));
         check((hcount > ex - 40) && (hcount < ex + 40), 1);
      end
      summarize;
   end
endmodule // output_terminal_mux_tb
